// ===== src/acff_pkg.sv
// Functional notes
// - set the input-low flag while sensed input is below the programmed lockout level.
// - clear the input-low flag by itself once input rises back above the level.
// - lockout detection works only while lockout enable (bit 7) is one.
// - both fault flags set regardless of their enables and the global enable.
// - lockout threshold is six bits in 5..0; bit 6 reads as zero.
// - overcurrent in a switching cycle sets its flag and drops high-side drive at once.
// - high-side drive returns at next switching cycle start, trips again if fault persists.
// - software clears overcurrent flag; it stays set until a clean switching cycle occurred.
// - overcurrent ignored for blanking after turn-on: 114, 213, 400 or 780 ns.
// - overcurrent detection works only while overcurrent enable (bit 7) is one.
// - five-bit overcurrent threshold field sets the drop limit, 160 to 625 mV.
// - four-bit AC gain field selects current-sense AC gain, 0 to 22 dB.
// - DC gain loop enable chooses whether DC-gained sense joins the control loop.
// - three-bit DC gain field selects DC gain, 19.5 to 35.7 dB.
package acff_pkg;
   localparam int CLK_PERIOD_NS = 25;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] OFS_LOCKOUT = 8'h00;
   localparam logic [7:0] OFS_OVERCURRENT = 8'h04;
   localparam logic [7:0] OFS_AC_GAIN = 8'h08;
   localparam logic [7:0] OFS_DC_GAIN = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
   localparam logic [7:0] OFS_IRQ_CONTROL = 8'h14;
   localparam logic [7:0] OFS_DRIVE = 8'h18;
   localparam int LOCK_EN_BIT = 7;
   localparam int LOCK_THR_W = 6;
   localparam int OC_EN_BIT = 7;
   localparam int BLANK_LSB = 5;
   localparam int BLANK_W = 2;
   localparam int OC_THR_W = 5;
   localparam int AC_GAIN_W = 4;
   localparam int DC_LOOP_BIT = 7;
   localparam int DC_GAIN_W = 3;
   localparam int IRQ_LOW_BIT = 0;
   localparam int IRQ_OC_BIT = 1;
   localparam int IRQ_GLOBAL_BIT = 7;
   localparam int DRV_INHIBIT_BIT = 0;
   localparam int DRV_HS_BIT = 1;
   localparam int DRV_BELOW_BIT = 2;
   localparam int DRV_CLEAN_BIT = 3;
   localparam logic [7:0] LOCKOUT_RST = 8'h00;
   localparam logic [7:0] OVERCURRENT_RST = 8'h00;
   localparam logic [7:0] AC_GAIN_RST = 8'h00;
   localparam logic [7:0] DC_GAIN_RST = 8'h00;
   localparam logic [7:0] IRQ_CONTROL_RST = 8'h00;
   localparam logic [7:0] LOCKOUT_MASK = 8'hbf;
   localparam logic [7:0] AC_GAIN_MASK = 8'h7f;
   localparam logic [7:0] DC_GAIN_MASK = 8'h8f;
   localparam logic [7:0] IRQ_CONTROL_MASK = 8'h83;
   localparam int BLANK_NS_0 = 114;
   localparam int BLANK_NS_1 = 213;
   localparam int BLANK_NS_2 = 400;
   localparam int BLANK_NS_3 = 780;
   localparam int BLANK_CNT_W = 6;

   // least times round up, and never below one cycle
   function automatic int ns_to_cycles(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam logic [5:0] BLANK_CYC_0 = 6'(ns_to_cycles(BLANK_NS_0));
   localparam logic [5:0] BLANK_CYC_1 = 6'(ns_to_cycles(BLANK_NS_1));
   localparam logic [5:0] BLANK_CYC_2 = 6'(ns_to_cycles(BLANK_NS_2));
   localparam logic [5:0] BLANK_CYC_3 = 6'(ns_to_cycles(BLANK_NS_3));

   typedef enum logic [1:0] {
      ACFF_HS_WAIT = 2'b00,
      ACFF_HS_BLANK = 2'b01,
      ACFF_HS_ON = 2'b11,
      ACFF_HS_TRIP = 2'b10
   } acff_hs_state_t;
endpackage

// ===== src/acff_sync.sv
`timescale 1ns/100ps
module acff_sync
   import acff_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] stage;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         stage <= '0;
         sync_o <= '0;
      end
      else
      begin
         stage <= async_i;
         sync_o <= stage;
      end
   end
endmodule

// ===== src/acff_blank.sv
`timescale 1ns/100ps
module acff_blank
   import acff_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [BLANK_W-1:0] select_i,
   output logic done_o
);
   logic [BLANK_CNT_W-1:0] count;
   logic [BLANK_CNT_W-1:0] load_value;
   logic [BLANK_CNT_W-1:0] next_count;

   assign load_value = (select_i == 2'h0) ? BLANK_CYC_0 :
                       (select_i == 2'h1) ? BLANK_CYC_1 :
                       (select_i == 2'h2) ? BLANK_CYC_2 : BLANK_CYC_3;
   assign next_count = start_i ? load_value :
                       (count != '0) ? count - 6'h01 : count;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         count <= '0;
         done_o <= 1'b0;
      end
      else
      begin
         count <= next_count;
         done_o <= (next_count == '0);
      end
   end
endmodule

// ===== src/acff_top.sv
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module acff_top
   import acff_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DATA_W-1:0] rdata_o,
   // analog comparators and oscillator, all asynchronous
   input wire logic vin_below_i,
   input wire logic oc_compare_i,
   input wire logic switch_clk_i,
   input wire logic on_time_end_i,
   // static configuration to the analog consumers
   output logic lockout_enable_o,
   output logic [LOCK_THR_W-1:0] lockout_threshold_o,
   output logic overcurrent_enable_o,
   output logic [BLANK_W-1:0] blanking_select_o,
   output logic [OC_THR_W-1:0] overcurrent_threshold_o,
   output logic [AC_GAIN_W-1:0] ac_gain_select_o,
   output logic dc_gain_loop_enable_o,
   output logic [DC_GAIN_W-1:0] dc_gain_select_o,
   // gate driver and interrupt
   output logic hs_drive_o,
   output logic irq_o
);
   // register storage
   logic [DATA_W-1:0] lockout_reg;
   logic [DATA_W-1:0] overcurrent_reg;
   logic [DATA_W-1:0] ac_gain_reg;
   logic [DATA_W-1:0] dc_gain_reg;
   logic [DATA_W-1:0] irq_control_reg;
   logic drive_inhibit;

   // fault flags and switching-cycle bookkeeping
   logic input_low_flag;
   logic overcurrent_flag;
   logic cycle_had_oc;
   logic oc_clean_seen;
   acff_hs_state_t hs_state;
   acff_hs_state_t next_hs_state;

   // synchronised pin inputs
   logic [3:0] pins_raw;
   logic [3:0] pins_sync;
   logic vin_below;
   logic oc_compare;
   logic switch_clk;
   logic on_time_end;
   logic switch_clk_prev;
   logic cycle_start;

   // decode
   // address selects, shared by the write strobes and the read mux
   logic sel_lockout;
   logic sel_overcurrent;
   logic sel_ac_gain;
   logic sel_dc_gain;
   logic sel_irq_status;
   logic sel_irq_control;
   logic sel_drive;
   logic wr_lockout;
   logic wr_overcurrent;
   logic wr_ac_gain;
   logic wr_dc_gain;
   logic wr_irq_status;
   logic wr_irq_control;
   logic wr_drive;
   logic clr_oc;
   logic [DATA_W-1:0] irq_status;
   logic [DATA_W-1:0] drive_status;
   logic [DATA_W-1:0] next_rdata;

   // datapath
   logic low_condition;
   logic oc_event;
   logic blank_start;
   logic blank_done;
   logic next_input_low_flag;
   logic next_overcurrent_flag;
   logic next_cycle_had_oc;
   logic next_oc_clean_seen;
   logic next_hs_drive;
   logic next_irq;
   logic hs_conducting;
   logic cycle_go;
   logic on_time_over;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   assign pins_raw = {on_time_end_i, switch_clk_i, oc_compare_i, vin_below_i};

   acff_sync #(
      .WIDTH(4)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(pins_raw),
      .sync_o(pins_sync)
   );

   assign vin_below = pins_sync[0];
   assign oc_compare = pins_sync[1];
   assign switch_clk = pins_sync[2];
   assign on_time_end = pins_sync[3];
   // a switching cycle begins on the rising edge of the oscillator
   assign cycle_start = switch_clk & ~switch_clk_prev;
   assign cycle_go = cycle_start & ~drive_inhibit;
   assign on_time_over = drive_inhibit | on_time_end;

   assign sel_lockout = hit(addr_i, OFS_LOCKOUT);
   assign sel_overcurrent = hit(addr_i, OFS_OVERCURRENT);
   assign sel_ac_gain = hit(addr_i, OFS_AC_GAIN);
   assign sel_dc_gain = hit(addr_i, OFS_DC_GAIN);
   assign sel_irq_status = hit(addr_i, OFS_IRQ_STATUS);
   assign sel_irq_control = hit(addr_i, OFS_IRQ_CONTROL);
   assign sel_drive = hit(addr_i, OFS_DRIVE);

   assign wr_lockout = wr_i & sel_lockout;
   assign wr_overcurrent = wr_i & sel_overcurrent;
   assign wr_ac_gain = wr_i & sel_ac_gain;
   assign wr_dc_gain = wr_i & sel_dc_gain;
   assign wr_irq_status = wr_i & sel_irq_status;
   assign wr_irq_control = wr_i & sel_irq_control;
   assign wr_drive = wr_i & sel_drive;
   assign clr_oc = wr_irq_status & wdata_i[IRQ_OC_BIT];

   // undervoltage: detection only with the lockout dac enabled
   assign low_condition = lockout_reg[LOCK_EN_BIT] & vin_below;

   // the flag tracks the comparator level, so a write-one has no effect; it clears
   // once the input is back above the threshold or the lockout enable (bit 7) is cleared
   assign next_input_low_flag = low_condition ? 1'b1 :
                                1'b0;

   // overcurrent counts only after blanking, while the high side conducts
   assign hs_conducting = (hs_state == ACFF_HS_ON);
   assign oc_event = hs_conducting & blank_done &
                     overcurrent_reg[OC_EN_BIT] & oc_compare;

   // set wins over clear; a clear is refused until a clean cycle has passed
   assign next_overcurrent_flag = oc_event ? 1'b1 :
                                  (clr_oc & oc_clean_seen) ? 1'b0 :
                                  overcurrent_flag;

   // a trip that meets a cycle start must not be lost to the start's clear
   assign next_cycle_had_oc = oc_event ? 1'b1 :
                              cycle_start ? 1'b0 : cycle_had_oc;

   // a cycle that ended with no trip proves the fault is gone
   assign next_oc_clean_seen = oc_event ? 1'b0 :
                               (cycle_start & ~cycle_had_oc) ? 1'b1 :
                               oc_clean_seen;

   assign blank_start = (next_hs_state == ACFF_HS_BLANK) & (hs_state != ACFF_HS_BLANK);

   acff_blank u_blank (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(blank_start),
      .select_i(overcurrent_reg[BLANK_LSB +: BLANK_W]),
      .done_o(blank_done)
   );

   // high-side drive sequencing; the inhibit bit is the firmware hook that
   // holds the driver off instead of the automatic retry
   always_comb
   begin
      next_hs_state = hs_state;
      unique case (hs_state)
         ACFF_HS_WAIT:
         begin
            if (cycle_go)
            begin
               next_hs_state = ACFF_HS_BLANK;
            end
         end
         ACFF_HS_BLANK:
         begin
            if (on_time_over)
            begin
               next_hs_state = ACFF_HS_WAIT;
            end
            else if (blank_done)
            begin
               next_hs_state = ACFF_HS_ON;
            end
         end
         ACFF_HS_ON:
         begin
            if (oc_event)
            begin
               next_hs_state = ACFF_HS_TRIP;
            end
            else if (on_time_over)
            begin
               next_hs_state = ACFF_HS_WAIT;
            end
         end
         ACFF_HS_TRIP:
         begin
            if (cycle_go)
            begin
               next_hs_state = ACFF_HS_BLANK;
            end
            else if (drive_inhibit)
            begin
               next_hs_state = ACFF_HS_WAIT;
            end
         end
      endcase
   end

   assign next_hs_drive = (next_hs_state == ACFF_HS_BLANK) |
                          (next_hs_state == ACFF_HS_ON);

   assign irq_status = {6'h00, overcurrent_flag, input_low_flag};
   assign drive_status = {4'h0, oc_clean_seen, vin_below, hs_drive_o, drive_inhibit};
   assign next_irq = irq_control_reg[IRQ_GLOBAL_BIT] &
                     (|(irq_status & irq_control_reg & 8'h03));

   // unmapped addresses read as zero; read data follow the strobe by one cycle
   assign next_rdata = ~rd_i ? 8'h00 :
                       sel_lockout ? lockout_reg & LOCKOUT_MASK :
                       sel_overcurrent ? overcurrent_reg :
                       sel_ac_gain ? ac_gain_reg & AC_GAIN_MASK :
                       sel_dc_gain ? dc_gain_reg & DC_GAIN_MASK :
                       sel_irq_status ? irq_status :
                       sel_irq_control ? irq_control_reg :
                       sel_drive ? drive_status : 8'h00;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         lockout_reg <= LOCKOUT_RST;
         overcurrent_reg <= OVERCURRENT_RST;
         ac_gain_reg <= AC_GAIN_RST;
         dc_gain_reg <= DC_GAIN_RST;
         irq_control_reg <= IRQ_CONTROL_RST;
         drive_inhibit <= 1'b0;
      end
      else
      begin
         if (wr_lockout)
         begin
            lockout_reg <= wdata_i & LOCKOUT_MASK;
         end
         if (wr_overcurrent)
         begin
            overcurrent_reg <= wdata_i;
         end
         if (wr_ac_gain)
         begin
            ac_gain_reg <= wdata_i & AC_GAIN_MASK;
         end
         if (wr_dc_gain)
         begin
            dc_gain_reg <= wdata_i & DC_GAIN_MASK;
         end
         if (wr_irq_control)
         begin
            irq_control_reg <= wdata_i & IRQ_CONTROL_MASK;
         end
         if (wr_drive)
         begin
            drive_inhibit <= wdata_i[DRV_INHIBIT_BIT];
         end
      end
   end

   // outputs to the analog side mirror the written value one cycle after the write
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         lockout_enable_o <= 1'b0;
         lockout_threshold_o <= '0;
         overcurrent_enable_o <= 1'b0;
         blanking_select_o <= '0;
         overcurrent_threshold_o <= '0;
         ac_gain_select_o <= '0;
         dc_gain_loop_enable_o <= 1'b0;
         dc_gain_select_o <= '0;
      end
      else
      begin
         lockout_enable_o <= lockout_reg[LOCK_EN_BIT];
         lockout_threshold_o <= lockout_reg[LOCK_THR_W-1:0];
         overcurrent_enable_o <= overcurrent_reg[OC_EN_BIT];
         blanking_select_o <= overcurrent_reg[BLANK_LSB +: BLANK_W];
         overcurrent_threshold_o <= overcurrent_reg[OC_THR_W-1:0];
         ac_gain_select_o <= ac_gain_reg[AC_GAIN_W-1:0];
         dc_gain_loop_enable_o <= dc_gain_reg[DC_LOOP_BIT];
         dc_gain_select_o <= dc_gain_reg[DC_GAIN_W-1:0];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         input_low_flag <= 1'b0;
         overcurrent_flag <= 1'b0;
         cycle_had_oc <= 1'b0;
         oc_clean_seen <= 1'b1;
         switch_clk_prev <= 1'b0;
         hs_state <= ACFF_HS_WAIT;
         hs_drive_o <= 1'b0;
      end
      else
      begin
         input_low_flag <= next_input_low_flag;
         overcurrent_flag <= next_overcurrent_flag;
         cycle_had_oc <= next_cycle_had_oc;
         oc_clean_seen <= next_oc_clean_seen;
         switch_clk_prev <= switch_clk;
         hs_state <= next_hs_state;
         hs_drive_o <= next_hs_drive;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rdata_o <= 8'h00;
         irq_o <= 1'b0;
      end
      else
      begin
         rdata_o <= next_rdata;
         irq_o <= next_irq;
      end
   end
endmodule

// ===== dv/acff_checker.sv
`timescale 1ns/100ps
module acff_checker
   import acff_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [DATA_W-1:0] rdata_o,
   input wire logic lockout_enable_o,
   input wire logic [LOCK_THR_W-1:0] lockout_threshold_o,
   input wire logic overcurrent_enable_o,
   input wire logic [BLANK_W-1:0] blanking_select_o,
   input wire logic [OC_THR_W-1:0] overcurrent_threshold_o,
   input wire logic [AC_GAIN_W-1:0] ac_gain_select_o,
   input wire logic dc_gain_loop_enable_o,
   input wire logic [DC_GAIN_W-1:0] dc_gain_select_o,
   input wire logic hs_drive_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_lock_cfg;
      wr_i && addr_i == OFS_LOCKOUT |-> ##2 lockout_enable_o == $past(wdata_i[7], 2)
         && lockout_threshold_o == $past(wdata_i[5:0], 2);
   endproperty
   a_lock_cfg: assert property (p_lock_cfg) else $error("lockout fields not applied");
   property p_oc_cfg;
      wr_i && addr_i == OFS_OVERCURRENT |-> ##2
         {overcurrent_enable_o, blanking_select_o, overcurrent_threshold_o} == $past(wdata_i, 2);
   endproperty
   a_oc_cfg: assert property (p_oc_cfg) else $error("overcurrent fields not applied");
   property p_ac_cfg;
      wr_i && addr_i == OFS_AC_GAIN |-> ##2 ac_gain_select_o == $past(wdata_i[3:0], 2);
   endproperty
   a_ac_cfg: assert property (p_ac_cfg) else $error("ac gain field not applied");
   property p_dc_cfg;
      wr_i && addr_i == OFS_DC_GAIN |-> ##2 dc_gain_select_o == $past(wdata_i[2:0], 2)
         && dc_gain_loop_enable_o == $past(wdata_i[7], 2);
   endproperty
   a_dc_cfg: assert property (p_dc_cfg) else $error("dc gain fields not applied");
   // outputs may only move two edges after an accepted write
   property p_cfg_stable;
      $past(wr_i, 2) == 1'b0 |-> $stable({lockout_enable_o, lockout_threshold_o,
         overcurrent_enable_o, blanking_select_o, overcurrent_threshold_o,
         ac_gain_select_o, dc_gain_loop_enable_o, dc_gain_select_o});
   endproperty
   a_cfg_stable: assert property (p_cfg_stable) else $error("config output moved");
   property p_lock_rd;
      rd_i && addr_i == OFS_LOCKOUT |=> rdata_o == {lockout_enable_o, 1'b0, lockout_threshold_o};
   endproperty
   a_lock_rd: assert property (p_lock_rd) else $error("lockout readback wrong");
   property p_oc_rd;
      rd_i && addr_i == OFS_OVERCURRENT |=>
         rdata_o == {overcurrent_enable_o, blanking_select_o, overcurrent_threshold_o};
   endproperty
   a_oc_rd: assert property (p_oc_rd) else $error("overcurrent readback wrong");
   property p_ac_rd;
      rd_i && addr_i == OFS_AC_GAIN |=> rdata_o[7] == 1'b0 && rdata_o[3:0] == ac_gain_select_o;
   endproperty
   a_ac_rd: assert property (p_ac_rd) else $error("ac gain readback wrong");
   property p_dc_rd;
      rd_i && addr_i == OFS_DC_GAIN |=> rdata_o[6:4] == 3'h0
         && rdata_o[7] == dc_gain_loop_enable_o && rdata_o[2:0] == dc_gain_select_o;
   endproperty
   a_dc_rd: assert property (p_dc_rd) else $error("dc gain readback wrong");
   c_oc_wr: cover property (wr_i && addr_i == OFS_OVERCURRENT);
   c_trip: cover property ($fell(hs_drive_o));
   c_irq: cover property ($rose(irq_o));
endmodule

bind acff_top acff_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .lockout_enable_o(lockout_enable_o), .lockout_threshold_o(lockout_threshold_o),
   .overcurrent_enable_o(overcurrent_enable_o), .blanking_select_o(blanking_select_o),
   .overcurrent_threshold_o(overcurrent_threshold_o), .ac_gain_select_o(ac_gain_select_o),
   .dc_gain_loop_enable_o(dc_gain_loop_enable_o), .dc_gain_select_o(dc_gain_select_o),
   .hs_drive_o(hs_drive_o), .irq_o(irq_o));

// ===== dv/tb_analog_config_fault_flags.sv
`timescale 1ns/100ps
module tb_analog_config_fault_flags;
   import acff_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic vin_below_i = 1'b0;
   logic oc_compare_i = 1'b0;
   logic switch_clk_i = 1'b0;
   logic on_time_end_i = 1'b0;
   wire logic [7:0] rdata_o;
   wire logic lk_en, oc_en, dc_en, hs_drive_o, irq_o;
   wire logic [5:0] lk_thr;
   wire logic [1:0] blank;
   wire logic [4:0] oc_thr;
   wire logic [3:0] ac_gain;
   wire logic [2:0] dc_gain;
   int n_fail = 0;
   int check_count = 0;
   logic [7:0] rd_val;

   always #12.5 clk_i = ~clk_i;

   acff_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .vin_below_i(vin_below_i),
      .oc_compare_i(oc_compare_i), .switch_clk_i(switch_clk_i), .on_time_end_i(on_time_end_i),
      .lockout_enable_o(lk_en), .lockout_threshold_o(lk_thr), .overcurrent_enable_o(oc_en),
      .blanking_select_o(blank), .overcurrent_threshold_o(oc_thr), .ac_gain_select_o(ac_gain),
      .dc_gain_loop_enable_o(dc_en), .dc_gain_select_o(dc_gain), .hs_drive_o(hs_drive_o),
      .irq_o(irq_o));

   task automatic final_report;
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe, so sample it there
   task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk(nm, rdata_o, e);
   endtask

   task automatic t_reset;
      for (int a = 0; a <= 8'h1c; a += 4)
         rdc("reset value", 8'(a), (a == OFS_DRIVE) ? 8'h08 : 8'h00);
   endtask

   task automatic t_config;
      logic [7:0] p;
      for (int i = 0; i < 2; i++)
      begin
         p = i ? 8'h6a : 8'hff;
         wr(OFS_LOCKOUT, p);
         wr(OFS_OVERCURRENT, p);
         wr(OFS_AC_GAIN, p);
         wr(OFS_DC_GAIN, p);
         wr(8'h1c, p);
         chk("lockout outputs", {lk_en, 1'b0, lk_thr}, p & 8'hbf);
         chk("overcurrent outputs", {oc_en, blank, oc_thr}, p);
         chk("ac gain output", {4'h0, ac_gain}, p & 8'h0f);
         chk("dc gain outputs", {dc_en, 4'h0, dc_gain}, p & 8'h87);
         rdc("lockout reg", OFS_LOCKOUT, p & 8'hbf);
         rdc("overcurrent reg", OFS_OVERCURRENT, p);
         rdc("ac gain reg", OFS_AC_GAIN, p & 8'h7f);
         rdc("dc gain reg", OFS_DC_GAIN, p & 8'h8f);
         rdc("unmapped", 8'h1c, 8'h00);
      end
   endtask

   task automatic t_lockout;
      vin_below_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rdc("flag while disabled", OFS_IRQ_STATUS, 8'h00);
      wr(OFS_LOCKOUT, 8'h95);
      repeat (4) @(posedge clk_i);
      rdc("input low flag", OFS_IRQ_STATUS, 8'h01);
      chk("irq while masked", {7'h0, irq_o}, 8'h00);
      wr(OFS_IRQ_STATUS, 8'h01);
      rdc("flag after clear", OFS_IRQ_STATUS, 8'h01);
      wr(OFS_IRQ_CONTROL, 8'h81);
      repeat (2) @(posedge clk_i);
      #1;
      chk("irq raised", {7'h0, irq_o}, 8'h01);
      vin_below_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      rdc("flag self clear", OFS_IRQ_STATUS, 8'h00);
      chk("irq dropped", {7'h0, irq_o}, 8'h00);
      wr(OFS_IRQ_CONTROL, 8'h00);
   endtask

   // one switching period; the on-time is ended by the peak signal after 40 cycles
   task automatic run_cycle(input logic oc, input logic on, output int hi);
      int k;
      oc_compare_i <= oc;
      @(posedge clk_i);
      switch_clk_i <= 1'b1;
      hi = 0;
      for (k = 0; k < 10 && hs_drive_o !== 1'b1; k++)
         @(posedge clk_i) #1;
      switch_clk_i <= 1'b0;
      chk("hs_drive_o turn on", {7'h0, hs_drive_o}, {7'h0, on});
      if (on && hs_drive_o !== 1'b1)
         final_report;
      else
      begin
         while (hs_drive_o === 1'b1 && hi < 40)
         begin
            hi++;
            @(posedge clk_i) #1;
         end
         on_time_end_i <= 1'b1;
         repeat (4) @(posedge clk_i);
         on_time_end_i <= 1'b0;
         repeat (4) @(posedge clk_i);
      end
   endtask

   task automatic t_overcurrent;
      int hi;
      int ns[4] = '{BLANK_NS_0, BLANK_NS_1, BLANK_NS_2, BLANK_NS_3};
      int b;
      for (int c = 0; c < 4; c++)
      begin
         wr(OFS_OVERCURRENT, 8'h9f | 8'(c << 5));
         run_cycle(1'b1, 1'b1, hi);
         b = (ns[c] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
         chk("blanked on-time in range", 8'(hi >= b && hi <= b + 3), 8'h01);
      end
      rdc("overcurrent flag", OFS_IRQ_STATUS, 8'h02);
      wr(OFS_IRQ_STATUS, 8'h02);
      rdc("flag without clean cycle", OFS_IRQ_STATUS, 8'h02);
      wr(OFS_IRQ_CONTROL, 8'h82);
      repeat (2) @(posedge clk_i);
      #1;
      chk("overcurrent irq", {7'h0, irq_o}, 8'h01);
      wr(OFS_IRQ_CONTROL, 8'h02);
      repeat (2) @(posedge clk_i);
      #1;
      chk("irq global off", {7'h0, irq_o}, 8'h00);
      run_cycle(1'b1, 1'b1, hi);
      chk("trip again", 8'(hi > 0 && hi < 40), 8'h01);
      run_cycle(1'b0, 1'b1, hi);
      chk("clean on-time", 8'(hi), 8'h28);
      wr(OFS_OVERCURRENT, 8'h1f);
      run_cycle(1'b1, 1'b1, hi);
      chk("disabled detector on-time", 8'(hi), 8'h28);
      // the clean cycle only counts once the following cycle has started
      wr(OFS_IRQ_STATUS, 8'h02);
      rdc("flag cleared", OFS_IRQ_STATUS, 8'h00);
      run_cycle(1'b1, 1'b1, hi);
      rdc("no flag when disabled", OFS_IRQ_STATUS, 8'h00);
      wr(OFS_DRIVE, 8'h01);
      run_cycle(1'b0, 1'b0, hi);
      wr(OFS_DRIVE, 8'h00);
   endtask

   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_config;
      t_lockout;
      t_overcurrent;
      final_report;
   end
endmodule
